// file: verilog/slclk_regs.vh
// constants for the serial link clocking block: register map, fields, widths, timing
`ifndef SLCLK_REGS_VH
`define SLCLK_REGS_VH
// register byte offsets
`define SLCLK_CTRL_OFF 8'h00
`define SLCLK_STAT_OFF 8'h04
`define SLCLK_RATE_OFF 8'h08
`define SLCLK_CFG_OFF 8'h0C
`define SLCLK_DIV_OFF 8'h10
// control fields
`define SLCLK_CTRL_FULLRST 0
`define SLCLK_CTRL_USEMOD 1
`define SLCLK_CTRL_HIRATE 2
`define SLCLK_CTRL_Q0_OK 3
`define SLCLK_CTRL_Q1_OK 4
`define SLCLK_CTRL_RST 32'h00000019
// line rate in Mb/s, reset 10.3125 Gb/s rounded to 10312
`define SLCLK_RATE_RST 32'h00002848
// band limits in Mb/s
`define SLCLK_BAND_CH 20'h01F40
`define SLCLK_BAND_Q1A 20'h032C8
`define SLCLK_BAND_Q0 20'h03FF7
`define SLCLK_BAND_Q1B 20'h04C90
`define SLCLK_BAND_OWNREF 20'h03FF7
// pll select codes
`define SLCLK_PLL_CH 2'h0
`define SLCLK_PLL_Q0 2'h1
`define SLCLK_PLL_Q1 2'h2
// widths
`define SLCLK_W64 7'h40
`define SLCLK_W32 7'h20
// timing: pll settle hold, 1000 ns at the 8 ns clock rounded up, in cycles
`define SLCLK_HOLD_CYC 16'h007D
// axi responses
`define SLCLK_RESP_OK 2'h0
`define SLCLK_RESP_DEC 2'h3
`endif

// file: verilog/slclk_sync3.v
// three-flop synchroniser with agreement on the last two stages
`timescale 1ns/1ns
`default_nettype none
module slclk_sync3 (
  input wire clk,
  input wire rst,
  input wire din,
  output reg dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // first stage feeds only the second
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule // slclk_sync3
`default_nettype wire

// file: verilog/slclk_ratediv.v
// enable-pulse divider giving the word-rate strobe from the fabric clock
`timescale 1ns/1ns
`default_nettype none
module slclk_ratediv (
  input wire clk,
  input wire rst,
  input wire [15:0] div,
  output reg tick
);
  reg [15:0] cnt_q;
  // one pulse every div+1 cycles, so zero gives every cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_q >= div) begin
      cnt_q <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule // slclk_ratediv
`default_nettype wire

// file: verilog/slclk_top.v
// clocking and lock handling of the serial link core, with an axi4-lite register slave
// Notes on behaviour
// R1 - all user exchange is on the fabric clock, buffered globally.
// R2 - fabric clock also drives the transceiver second transmit user clock.
// R3 - word clock from global buffer drives first transmit clock and sync logic.
// R4 - output clock chosen so parallel rate matches line rate after 66-bit coding.
// R5 - without clock module, unlocked input is the inverted pll lock.
// R6 - pll hold keeps pll in reset until its source clock is stable.
// R7 - with clock module, hold feeds its unlocked port, its unlocked drives core.
// R8 - lock synchronisation runs in the free-running init clock domain.
// R9 - full reset stays asserted until an init clock manager locks.
// R10 - datapath eight-byte aligned; lower families transmit eight, receive four bytes.
// R11 - lower families: transmit width 64, other three widths 32.
// R12 - highest-rate family: all four widths 64.
// R13 - user clock rate equals line rate over internal width.
// R14 - pll chosen by line-rate band, other quad pll as fallback.
// R15 - highest family above 16.375 Gb/s uses each quad's own reference clock.
// R16 - bonding and compensation on recovered clock; buffer count fixed.
// R17 - user side should register every boundary signal.
// R18 - full transceiver reset resets the transceiver and the whole core.
// R19 - unlocked indication passes a synchroniser before gating reset release.
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "slclk_regs.vh"
module slclk_top #(
  parameter [15:0] HOLD_CYC = `SLCLK_HOLD_CYC
) (
  input wire clk,
  input wire rst,
  input wire pll_locked,
  input wire module_unlocked,
  input wire init_mgr_locked,
  input wire out_clk_seen,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg pll_hold,
  output reg core_reset,
  output reg xcvr_full_reset,
  output reg [1:0] pll_sel,
  output reg own_refclk,
  output reg [6:0] tx_width,
  output reg [6:0] tx_int_width,
  output reg [6:0] rx_width,
  output reg [6:0] rx_int_width,
  output reg word_tick
);
  // state machine for the pll hold sequence, one-hot
  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  reg [31:0] ctrl_q;
  reg [31:0] rate_q;
  reg [15:0] div_q;
  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [15:0] hold_cnt_q;
  reg [15:0] hold_cnt_d;
  reg aw_got_q;
  reg w_got_q;
  reg [7:0] aw_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  reg lock_lost_q;
  wire unlk_raw;
  wire unlk_sync;
  wire seen_sync;
  wire mgr_lock_sync;
  wire tick_w;
  wire [19:0] rate_mbps;
  wire use_mod;
  wire hirate;

  assign use_mod = ctrl_q[`SLCLK_CTRL_USEMOD];
  assign hirate = ctrl_q[`SLCLK_CTRL_HIRATE];
  assign rate_mbps = rate_q[19:0];

  // choose the unlocked source: clock module output, or inverted pll lock
  assign unlk_raw = use_mod ? module_unlocked : ~pll_locked; // [R5] [R7]

  // lock and clock-present indications sampled in the free-running domain
  slclk_sync3 u_sync_unlk (
    .clk(clk),
    .rst(rst),
    .din(unlk_raw),
    .dout(unlk_sync)
  ); // [R8] [R19]
  slclk_sync3 u_sync_seen (
    .clk(clk),
    .rst(rst),
    .din(~out_clk_seen),
    .dout(seen_sync)
  );
  slclk_sync3 u_sync_mgr (
    .clk(clk),
    .rst(rst),
    .din(~init_mgr_locked),
    .dout(mgr_lock_sync)
  );

  // word-rate strobe; software sets divisor from line rate over internal width
  slclk_ratediv u_div (
    .clk(clk),
    .rst(rst),
    .div(div_q),
    .tick(tick_w)
  ); // [R13]

  // pick the pll by band; fall back to the other quad pll if absent
  function [1:0] pll_pick;
    input [19:0] mbps;
    input q0_ok;
    input q1_ok;
    reg want_q1;
    begin
      want_q1 = 1'b0;
      if (mbps <= `SLCLK_BAND_CH) begin
        pll_pick = `SLCLK_PLL_CH;
      end else begin
        if (mbps <= `SLCLK_BAND_Q1A) begin
          want_q1 = 1'b1;
        end else if (mbps <= `SLCLK_BAND_Q0) begin
          want_q1 = 1'b0;
        end else if (mbps <= `SLCLK_BAND_Q1B) begin
          want_q1 = 1'b1;
        end else begin
          want_q1 = 1'b0;
        end
        if (want_q1) begin
          pll_pick = q1_ok ? `SLCLK_PLL_Q1 : `SLCLK_PLL_Q0;
        end else begin
          pll_pick = q0_ok ? `SLCLK_PLL_Q0 : `SLCLK_PLL_Q1;
        end
      end
    end
  endfunction

  // hold sequence: full reset and manager lock restart the wait
  always @* begin
    st_d = st_q;
    hold_cnt_d = hold_cnt_q;
    case (st_q)
      ST_HOLD: begin
        hold_cnt_d = 16'h0000;
        if (!ctrl_q[`SLCLK_CTRL_FULLRST] && !mgr_lock_sync && !seen_sync) begin
          st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // source clock must stay present for the whole settle time
        if (ctrl_q[`SLCLK_CTRL_FULLRST] || mgr_lock_sync || seen_sync) begin
          st_d = ST_HOLD;
        end else if (hold_cnt_q >= HOLD_CYC) begin
          st_d = ST_RUN;
        end else begin
          hold_cnt_d = hold_cnt_q + 16'h0001;
        end
      end
      ST_RUN: begin
        if (ctrl_q[`SLCLK_CTRL_FULLRST] || mgr_lock_sync || seen_sync) begin
          st_d = ST_HOLD;
        end
      end
      default: begin
        st_d = ST_HOLD;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_HOLD;
      hold_cnt_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end

  // no mode adds a clock or buffer; bonding and compensation live elsewhere [R16]
  // registered clocking outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pll_hold <= 1'b1;
      xcvr_full_reset <= 1'b1;
      core_reset <= 1'b1;
      pll_sel <= `SLCLK_PLL_CH;
      own_refclk <= 1'b0;
      tx_width <= `SLCLK_W64;
      tx_int_width <= `SLCLK_W32;
      rx_width <= `SLCLK_W32;
      rx_int_width <= `SLCLK_W32;
      word_tick <= 1'b0;
      lock_lost_q <= 1'b0;
    end else begin
      pll_hold <= (st_q != ST_RUN); // [R6]
      // full reset held while the init manager is unlocked
      xcvr_full_reset <= ctrl_q[`SLCLK_CTRL_FULLRST] | mgr_lock_sync; // [R9] [R18]
      // core only leaves reset with pll running and synced lock seen
      core_reset <= (st_q != ST_RUN) | unlk_sync; // [R18] [R19]
      pll_sel <= pll_pick(rate_mbps, ctrl_q[`SLCLK_CTRL_Q0_OK],
        ctrl_q[`SLCLK_CTRL_Q1_OK]); // [R14]
      own_refclk <= hirate && (rate_mbps > `SLCLK_BAND_OWNREF); // [R15]
      // widths: eight-byte user path; receive narrower on lower families
      tx_width <= `SLCLK_W64; // [R10]
      tx_int_width <= hirate ? `SLCLK_W64 : `SLCLK_W32; // [R11] [R12]
      rx_width <= hirate ? `SLCLK_W64 : `SLCLK_W32; // [R11] [R12]
      rx_int_width <= hirate ? `SLCLK_W64 : `SLCLK_W32; // [R11] [R12]
      word_tick <= tick_w; // [R4]
      // sticky lock loss; set wins over a write-one clear
      if (st_q == ST_RUN && unlk_sync) begin
        lock_lost_q <= 1'b1;
      end else if (s_axi_bvalid == 1'b0 && aw_got_q && w_got_q &&
                   aw_q == `SLCLK_STAT_OFF && ws_q[0] && wd_q[4]) begin
        lock_lost_q <= 1'b0;
      end
    end
  end

  // axi4-lite write: address and data taken in either order, one at a time [R1]
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SLCLK_RESP_OK;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      ctrl_q <= `SLCLK_CTRL_RST;
      rate_q <= `SLCLK_RATE_RST;
      div_q <= 16'h0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr[7:0];
        aw_got_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        w_got_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SLCLK_RESP_OK;
        case (aw_q)
          `SLCLK_CTRL_OFF: begin
            if (ws_q[0]) begin
              ctrl_q[7:0] <= wd_q[7:0];
            end
          end
          `SLCLK_RATE_OFF: begin
            if (ws_q[0]) begin
              rate_q[7:0] <= wd_q[7:0];
            end
            if (ws_q[1]) begin
              rate_q[15:8] <= wd_q[15:8];
            end
            if (ws_q[2]) begin
              rate_q[19:16] <= wd_q[19:16];
            end
          end
          `SLCLK_DIV_OFF: begin
            if (ws_q[0]) begin
              div_q[7:0] <= wd_q[7:0];
            end
            if (ws_q[1]) begin
              div_q[15:8] <= wd_q[15:8];
            end
          end
          `SLCLK_STAT_OFF: begin
            s_axi_bresp <= `SLCLK_RESP_OK;
          end
          `SLCLK_CFG_OFF: begin
            s_axi_bresp <= `SLCLK_RESP_OK;
          end
          default: begin
            s_axi_bresp <= `SLCLK_RESP_DEC;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi4-lite read: one cycle from address to data [R1]
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SLCLK_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SLCLK_RESP_OK;
      case (s_axi_araddr[7:0])
        `SLCLK_CTRL_OFF: s_axi_rdata <= {24'h000000, ctrl_q[7:0]};
        `SLCLK_STAT_OFF: s_axi_rdata <= {24'h000000, own_refclk, pll_sel,
          lock_lost_q, unlk_sync, core_reset, xcvr_full_reset, pll_hold};
        `SLCLK_RATE_OFF: s_axi_rdata <= {12'h000, rate_q[19:0]};
        `SLCLK_CFG_OFF: s_axi_rdata <= {4'h0, tx_width, tx_int_width, rx_width,
          rx_int_width};
        `SLCLK_DIV_OFF: s_axi_rdata <= {16'h0000, div_q};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SLCLK_RESP_DEC;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // slclk_top
`default_nettype wire

// file: verification/slclk_checker.sv
// port assertions for the clocking block
`timescale 1ns/1ns
`default_nettype none
`include "slclk_regs.vh"
module slclk_checker #(
  parameter [15:0] HOLD_CYC = `SLCLK_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pll_hold,
  input wire logic core_reset,
  input wire logic xcvr_full_reset,
  input wire logic [1:0] pll_sel,
  input wire logic own_refclk,
  input wire logic [6:0] tx_width,
  input wire logic [6:0] tx_int_width,
  input wire logic [6:0] rx_width,
  input wire logic [6:0] rx_int_width,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  logic [15:0] held_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // cycles of hold with full reset already gone, so settle time is measurable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) held_q <= 16'h0000;
    else if (pll_hold && !xcvr_full_reset) held_q <= held_q + 16'h0001;
    else held_q <= 16'h0000;
  end
  hold_len_a: assert property ($fell(pll_hold) |-> held_q >= HOLD_CYC)
    else $error("hold released early");
  full_core_a: assert property (xcvr_full_reset [*3] |-> core_reset && pll_hold)
    else $error("core free in full reset");
  hold_core_a: assert property (pll_hold [*3] |-> core_reset)
    else $error("core free while pll held");
  tx_width_a: assert property (tx_width == `SLCLK_W64)
    else $error("tx width not 64");
  width_set_a: assert property (tx_int_width == rx_width && rx_width == rx_int_width
    && (rx_width == `SLCLK_W32 || rx_width == `SLCLK_W64))
    else $error("width set inconsistent");
  sel_code_a: assert property (pll_sel != 2'h3)
    else $error("bad pll select");
  own_ref_a: assert property (own_refclk |-> pll_sel != `SLCLK_PLL_CH && rx_width == `SLCLK_W64)
    else $error("own refclk off band");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  busy_wr_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  busy_rd_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  hold_end_c: cover property ($fell(pll_hold));
  core_up_c: cover property ($fell(core_reset));
  own_ref_c: cover property (own_refclk);
endmodule // slclk_checker
bind slclk_top slclk_checker #(.HOLD_CYC(HOLD_CYC)) u_chk (.*);
`default_nettype wire

// file: verification/slclk_partner.sv
// behavioural model of the pll and clock managers beside the block
`timescale 1ns/1ns
`default_nettype none
module slclk_partner (
  input wire logic clk, // fabric clock feeds the second transmit user clock port; the word clock feeds the first
  input wire logic pll_hold,
  input wire logic lose_lock,
  input wire logic mgr_up,
  output logic pll_locked,
  output logic module_unlocked,
  output logic init_mgr_locked = 1'b0,
  output logic out_clk_seen = 1'b0
);
  logic [3:0] lock_q = 4'h0;
  // pll settles for a few cycles once out of reset; hold or a glitch restarts it
  always_ff @(posedge clk) begin
    if (pll_hold || lose_lock) lock_q <= 4'h0;
    else if (lock_q != 4'hF) lock_q <= lock_q + 4'h1;
  end
  // the module's unlocked flag is the exact inverse of the lock
  assign pll_locked = lock_q > 4'h5;
  assign module_unlocked = !pll_locked;
  // init manager locks when powered; output clock is seen a cycle later
  always_ff @(posedge clk) begin
    init_mgr_locked <= mgr_up;
    out_clk_seen <= init_mgr_locked;
  end
endmodule // slclk_partner
`default_nettype wire

// file: verification/slclk_top_tb_top.sv
// self-checking bench for the clocking block
`timescale 1ns/1ns
`default_nettype none
`include "slclk_regs.vh"
module slclk_top_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic lose_lock = 1'b0;
  logic mgr_up = 1'b0;
  logic pll_locked, module_unlocked, init_mgr_locked, out_clk_seen;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, pll_sel;
  logic pll_hold, core_reset, xcvr_full_reset, own_refclk, word_tick;
  logic [6:0] tx_width, tx_int_width, rx_width, rx_int_width;
  logic [33:0] rq[$];
  logic [33:0] e;
  int fails = 0, tests_run = 0, cyc = 0, n;
  int edges[8] = '{8000, 8001, 13000, 13001, 16375, 16376, 19600, 19601};
  slclk_top #(.HOLD_CYC(16'h0004)) uut (.*);
  slclk_partner model (.*);
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one write from registered drives, bready raised after a random stall
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (!s_axi_bready) s_axi_bready <= 1'($urandom_range(0, 1));
    end while (!(s_axi_bvalid && s_axi_bready));
    chk("bresp", 32'(s_axi_bresp), 32'(`SLCLK_RESP_OK));
    s_axi_bready <= 1'b0;
  endtask
  // one read; the expected word waits in the queue for the monitor
  task automatic rd(input logic [7:0] a, input logic [33:0] x);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    rq.push_back(x);
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (!s_axi_rready) s_axi_rready <= 1'($urandom_range(0, 1));
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [1:0] exp_sel(input int r, input logic q0, input logic q1);
    if (r <= 8000) return `SLCLK_PLL_CH;
    if (r <= 13000 || (r > 16375 && r <= 19600)) return q1 ? `SLCLK_PLL_Q1 : `SLCLK_PLL_Q0;
    if (r <= 16375) return q0 ? `SLCLK_PLL_Q0 : `SLCLK_PLL_Q1;
    return `SLCLK_PLL_Q0;
  endfunction
  task automatic band(input logic [7:0] ctl, input int r);
    wr(`SLCLK_CTRL_OFF, {24'h0, ctl});
    wr(`SLCLK_RATE_OFF, r);
    repeat (2) @(posedge clk);
    chk("pll_sel", 32'(pll_sel), 32'(exp_sel(r, ctl[3], ctl[4])));
    chk("own_refclk", 32'(own_refclk), 32'(ctl[2] && r > 16375));
  endtask
  // monitor: each read answer against the oldest note
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      chk("rdata", s_axi_rdata, e[31:0]);
      chk("rresp", 32'(s_axi_rresp), 32'(e[33:32]));
    end
  end
  // hang guard, far above the expected few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(32'hA7B4));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("hold", 32'(pll_hold), 32'h1);
    chk("full", 32'(xcvr_full_reset), 32'h1);
    rd(`SLCLK_CTRL_OFF, {`SLCLK_RESP_OK, `SLCLK_CTRL_RST});
    rd(`SLCLK_RATE_OFF, {`SLCLK_RESP_OK, `SLCLK_RATE_RST});
    rd(8'h14, {`SLCLK_RESP_DEC, 32'h0});
    rd(`SLCLK_CFG_OFF, {`SLCLK_RESP_OK, 4'h0, `SLCLK_W64, {3{`SLCLK_W32}}});
    $display("test reset done");
    // band edges, random rates, fallbacks and the top family
    foreach (edges[i]) band(8'h18, edges[i]);
    repeat (8) band(8'h18, int'($urandom_range(1, 25000)));
    band(8'h10, 14000);
    band(8'h08, 10000);
    band(8'h1C, 17000);
    rd(`SLCLK_CFG_OFF, {`SLCLK_RESP_OK, 4'h0, {4{`SLCLK_W64}}});
    band(8'h1C, 16375);
    $display("test bands done");
    // no init lock, no release; then lock, loss of lock, full reset again
    repeat (20) @(posedge clk);
    chk("hold_nomgr", 32'(pll_hold), 32'h1);
    mgr_up <= 1'b1;
    n = 0;
    while (core_reset !== 1'b0 && n < 80) begin
      @(posedge clk);
      n++;
    end
    chk("hold_off", 32'(pll_hold), 32'h0);
    chk("core_up", 32'(core_reset), 32'h0);
    lose_lock <= 1'b1;
    repeat (8) @(posedge clk);
    chk("core_lost", 32'(core_reset), 32'h1);
    lose_lock <= 1'b0;
    wr(`SLCLK_CTRL_OFF, `SLCLK_CTRL_RST);
    repeat (3) @(posedge clk);
    chk("full_again", 32'(xcvr_full_reset), 32'h1);
    chk("core_full", 32'(core_reset), 32'h1);
    // lock-lost flag: seen after the loss, cleared by writing one to it
    repeat (8) @(posedge clk);
    rd(`SLCLK_STAT_OFF, {`SLCLK_RESP_OK, 32'h0000003F});
    wr(`SLCLK_STAT_OFF, 32'h10);
    rd(`SLCLK_STAT_OFF, {`SLCLK_RESP_OK, 32'h0000002F});
    // clock module path: its unlocked flag now gates the core
    wr(`SLCLK_CTRL_OFF, 32'h1A);
    n = 0;
    while (core_reset !== 1'b0 && n < 80) begin
      @(posedge clk);
      n++;
    end
    chk("core_mod", 32'(core_reset), 32'h0);
    $display("test hold done");
    // word strobe spacing after the divisor is set
    wr(`SLCLK_DIV_OFF, 32'h3);
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (word_tick !== 1'b1 && n < 40);
    end
    chk("tick_gap", n, 32'h4);
    $display("test tick done");
    tally_and_finish();
  end
endmodule // slclk_top_tb_top
`default_nettype wire
